// file: pkg/sfa_pkg.sv
package sfa_pkg;

    // Command opcodes
    localparam logic [7:0] SFA_OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] SFA_OP_PARAM_ERASE = 8'h40;
    localparam logic [7:0] SFA_OP_BULK_ERASE = 8'hC7;
    localparam logic [7:0] SFA_OP_SECTOR_ERASE = 8'hD8;
    // Lock opcode value is arbitrary
    localparam logic [7:0] SFA_OP_OTP_LOCK = 8'hA5;

    // Address layout
    localparam int SFA_ADDR_W = 24;
    localparam int SFA_SECTOR_LSB = 16;
    localparam int SFA_PARAM_LSB = 13;
    localparam int SFA_PAGE_LSB = 8;
    localparam int SFA_ARRAY_MSB = 22;
    localparam logic [6:0] SFA_MAX_SECTOR = 7'h7F;

    // Erase extent as log2 of bytes
    localparam logic [4:0] SFA_SZ_PARAM = 5'h0D;
    localparam logic [4:0] SFA_SZ_SECTOR = 5'h10;
    localparam logic [4:0] SFA_SZ_BULK = 5'h17;

    // One-time-programmable register grouping
    localparam int SFA_OTP_REGS = 33;
    localparam logic [4:0] SFA_OTP_SMALL_BYTES = 5'h08;
    localparam logic [4:0] SFA_OTP_MID_BYTES = 5'h10;
    localparam logic [4:0] SFA_OTP_LAST_BYTES = 5'h0A;
    localparam logic [7:0] SFA_OTP_SMALL_CNT = 8'h02;
    localparam logic [7:0] SFA_OTP_MID_END = 8'h20;

    // Data buffer
    localparam int SFA_FIFO_W = 32;
    localparam int SFA_FIFO_D = 8;

    // Serial frame bit counts
    localparam logic [5:0] SFA_BITS_OPCODE = 6'h08;
    localparam logic [5:0] SFA_BITS_ADDR_END = 6'h20;

    typedef enum logic [1:0] {
        SFA_ER_PARAM = 2'h0,
        SFA_ER_SECTOR = 2'h1,
        SFA_ER_BULK = 2'h2
    } sfa_erase_t;

    typedef enum logic [3:0] {
        SFA_ST_OPCODE = 4'h1,
        SFA_ST_ADDR = 4'h2,
        SFA_ST_DATA = 4'h4,
        SFA_ST_IGNORE = 4'h8
    } sfa_state_t;

endpackage

// file: rtl/sfa_fifo.sv
`timescale 1ns/1ps
module sfa_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // sfa_fifo

// file: rtl/sfa_array_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Sector erase clears one sector or eight blocks
// - Block erase clears one block, else nothing
// - Bulk erase clears the whole array
// - Program writes within one 256-byte page
// - Repeated programs to a page are accepted
// - Eight 8-Kbyte blocks fill lowest 64 Kbytes
// - Sector n is address bits 22 to 16
// - OTP grouped 2x8, 30x16, 1x10, each locked
// - Bits sampled on rising clock, MSB first
// - Select low frames command, high ends it
module sfa_array_ctrl
    import sfa_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic spi_clk,
    input wire logic spi_sel_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    output logic erase_valid,
    input wire logic erase_ready,
    output sfa_erase_t erase_kind,
    output logic [SFA_ADDR_W-1:0] erase_base,
    output logic [4:0] erase_size_log2,
    output logic prog_valid,
    input wire logic prog_ready,
    output logic [SFA_ADDR_W-1:0] prog_addr,
    output logic [7:0] prog_data,
    output logic prog_overrun,
    output logic [SFA_OTP_REGS-1:0] otp_lock
);
    // Size of one OTP register, zero for an index that does not exist
    function automatic logic [4:0] otp_reg_bytes(input logic [7:0] idx);
        if (idx < SFA_OTP_SMALL_CNT) begin
            otp_reg_bytes = SFA_OTP_SMALL_BYTES;
        end else if (idx < SFA_OTP_MID_END) begin
            otp_reg_bytes = SFA_OTP_MID_BYTES;
        end else if (idx == SFA_OTP_MID_END) begin
            otp_reg_bytes = SFA_OTP_LAST_BYTES;
        end else begin
            otp_reg_bytes = 5'h00;
        end
    endfunction

    // Opcodes that are followed by three address bytes
    function automatic logic op_takes_addr(input logic [7:0] op);
        op_takes_addr = (op == SFA_OP_PAGE_PROG) || (op == SFA_OP_PARAM_ERASE) ||
                        (op == SFA_OP_SECTOR_ERASE) || (op == SFA_OP_OTP_LOCK);
    endfunction

    // Pin synchronisers, third stage only for edge detection
    logic [2:0] clk_s_q;
    logic [2:0] sel_s_q;
    logic [1:0] mosi_s_q;
    sfa_state_t state_q, state_d;
    logic [5:0] bits_q;
    logic [7:0] shift_q;
    logic [7:0] opcode_q;
    logic [SFA_ADDR_W-1:0] addr_q;
    logic byte_pend_q;
    logic [7:0] byte_q;
    logic [SFA_ADDR_W-1:0] byte_addr_q;
    logic erase_valid_q;
    sfa_erase_t erase_kind_q;
    logic [SFA_ADDR_W-1:0] erase_base_q;
    logic [4:0] erase_size_q;
    logic overrun_q;
    logic [SFA_OTP_REGS-1:0] lock_q;
    logic fifo_in_ready;
    logic [SFA_FIFO_W-1:0] fifo_out;

    wire clk_rise = clk_s_q[1] && !clk_s_q[2];
    wire sel_low = !sel_s_q[1];
    wire sel_rise = sel_s_q[1] && !sel_s_q[2];
    wire bit_in = clk_rise && sel_low;
    wire [7:0] shift_next = {shift_q[6:0], mosi_s_q[1]};
    wire byte_done = bit_in && (bits_q[2:0] == 3'h7);
    wire opcode_done = bit_in && (bits_q == SFA_BITS_OPCODE - 6'h01);
    wire addr_done = bit_in && (bits_q == SFA_BITS_ADDR_END - 6'h01);
    wire frame_whole = (bits_q == SFA_BITS_ADDR_END);
    wire op_is_prog = (opcode_q == SFA_OP_PAGE_PROG);
    wire busy = erase_valid_q;

    wire [6:0] sector_idx = addr_q[SFA_ARRAY_MSB:SFA_SECTOR_LSB];
    wire [2:0] param_idx = addr_q[SFA_SECTOR_LSB-1:SFA_PARAM_LSB];
    wire in_param_space = (sector_idx == 7'h00);
    wire [SFA_ADDR_W-1:0] sector_base = {1'b0, sector_idx, 16'h0000};
    wire [SFA_ADDR_W-1:0] param_base = {8'h00, param_idx, 13'h0000};
    wire sector_ok = (sector_idx <= SFA_MAX_SECTOR);
    wire [7:0] otp_idx = addr_q[7:0];
    wire otp_ok = (otp_reg_bytes(otp_idx) != 5'h00);
    wire end_sector = sel_rise && frame_whole && (opcode_q == SFA_OP_SECTOR_ERASE) && sector_ok;
    wire end_param = sel_rise && frame_whole && (opcode_q == SFA_OP_PARAM_ERASE) && in_param_space;
    wire end_bulk = sel_rise && (bits_q == SFA_BITS_OPCODE) && (opcode_q == SFA_OP_BULK_ERASE);
    wire end_lock = sel_rise && frame_whole && (opcode_q == SFA_OP_OTP_LOCK) && otp_ok;
    wire [7:0] next_col = addr_q[SFA_PAGE_LSB-1:0] + 8'h01;

    // Command walk
    always_comb begin
        state_d = state_q;
        case (state_q)
            SFA_ST_OPCODE: begin
                if (opcode_done) begin
                    state_d = (!busy && op_takes_addr(shift_next)) ? SFA_ST_ADDR : SFA_ST_IGNORE;
                end
            end
            SFA_ST_ADDR: begin
                if (addr_done) begin
                    state_d = op_is_prog ? SFA_ST_DATA : SFA_ST_IGNORE;
                end
            end
            SFA_ST_DATA: state_d = SFA_ST_DATA;
            SFA_ST_IGNORE: state_d = SFA_ST_IGNORE;
            default: state_d = SFA_ST_OPCODE;
        endcase
        if (!sel_low) begin
            state_d = SFA_ST_OPCODE;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            clk_s_q <= 3'h0;
            sel_s_q <= 3'h7;
            mosi_s_q <= 2'h0;
        end else begin
            clk_s_q <= {clk_s_q[1:0], spi_clk};
            sel_s_q <= {sel_s_q[1:0], spi_sel_n};
            mosi_s_q <= {mosi_s_q[0], spi_mosi};
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= SFA_ST_OPCODE;
            bits_q <= 6'h00;
            shift_q <= 8'h00;
            opcode_q <= 8'h00;
            addr_q <= '0;
        end else begin
            state_q <= state_d;
            if (!sel_low) begin
                bits_q <= 6'h00;
            end else if (bit_in && bits_q == 6'h3F && state_q == SFA_ST_DATA) begin
                // Long programs fold back onto a byte boundary
                bits_q <= 6'h38;
            end else if (bit_in && bits_q != 6'h3F) begin
                bits_q <= bits_q + 6'h01;
            end
            if (bit_in) begin
                shift_q <= shift_next;
            end
            // Refused frame keeps no opcode, so it ends in no action
            if (opcode_done) begin
                opcode_q <= busy ? 8'h00 : shift_next;
            end
            if (byte_done && state_q == SFA_ST_ADDR) begin
                addr_q <= {addr_q[SFA_ADDR_W-9:0], shift_next};
            end else if (byte_done && state_q == SFA_ST_DATA) begin
                addr_q <= {addr_q[SFA_ADDR_W-1:SFA_PAGE_LSB], next_col};
            end
        end
    end

    // Program bytes staged toward the buffer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            byte_pend_q <= 1'b0;
            byte_q <= 8'h00;
            byte_addr_q <= '0;
            overrun_q <= 1'b0;
        end else begin
            if (byte_done && state_q == SFA_ST_DATA) begin
                byte_pend_q <= 1'b1;
                byte_q <= shift_next;
                byte_addr_q <= addr_q;
                if (byte_pend_q && !fifo_in_ready) begin
                    overrun_q <= 1'b1;
                end
            end else if (fifo_in_ready) begin
                byte_pend_q <= 1'b0;
            end
            if (sel_low && bits_q == 6'h00) begin
                overrun_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            erase_valid_q <= 1'b0;
            erase_kind_q <= SFA_ER_SECTOR;
            erase_base_q <= '0;
            erase_size_q <= 5'h00;
        end else if (erase_valid_q) begin
            if (erase_ready) begin
                erase_valid_q <= 1'b0;
            end
        end else if (end_sector) begin
            erase_valid_q <= 1'b1;
            erase_kind_q <= SFA_ER_SECTOR;
            erase_base_q <= sector_base;
            erase_size_q <= SFA_SZ_SECTOR;
        end else if (end_param) begin
            erase_valid_q <= 1'b1;
            erase_kind_q <= SFA_ER_PARAM;
            erase_base_q <= param_base;
            erase_size_q <= SFA_SZ_PARAM;
        end else if (end_bulk) begin
            erase_valid_q <= 1'b1;
            erase_kind_q <= SFA_ER_BULK;
            erase_base_q <= '0;
            erase_size_q <= SFA_SZ_BULK;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lock_q <= '0;
        end else if (end_lock) begin
            lock_q[otp_idx[5:0]] <= 1'b1;
        end
    end

    sfa_fifo #(
        .WIDTH(SFA_FIFO_W),
        .DEPTH(SFA_FIFO_D)
    ) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(byte_pend_q),
        .in_ready(fifo_in_ready),
        .in_data({byte_addr_q, byte_q}),
        .out_valid(prog_valid),
        .out_ready(prog_ready),
        .out_data(fifo_out)
    );

    assign prog_addr = fifo_out[SFA_FIFO_W-1:8];
    assign prog_data = fifo_out[7:0];
    assign prog_overrun = overrun_q;
    assign erase_valid = erase_valid_q;
    assign erase_kind = erase_kind_q;
    assign erase_base = erase_base_q;
    assign erase_size_log2 = erase_size_q;
    assign otp_lock = lock_q;
    // No command here returns data, output stays released
    assign spi_miso = 1'b1;
    assign spi_miso_oe = 1'b0;
endmodule // sfa_array_ctrl

// file: dv/sfa_spi_host.sv
`timescale 1ns/1ps
module sfa_spi_host (
    input wire logic core_clk,
    output logic spi_clk,
    output logic spi_sel_n,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe
);
    initial begin
        spi_clk = 1'b0;
        spi_sel_n = 1'b1;
        spi_mosi = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = b[i];
            wait_n(4);
            spi_clk = 1'b1;
            wait_n(4);
            spi_clk = 1'b0;
        end
    endtask
    task automatic put_addr(input logic [23:0] a);
        put_byte(a[23:16]);
        put_byte(a[15:8]);
        put_byte(a[7:0]);
    endtask
    task automatic start(input logic [7:0] op);
        spi_sel_n = 1'b0;
        wait_n(4);
        put_byte(op);
    endtask
    task automatic stop();
        wait_n(4);
        spi_sel_n = 1'b1;
        spi_mosi = ~spi_mosi;
        wait_n(8);
    endtask
endmodule // sfa_spi_host

// file: dv/sfa_array_ctrl_checker.sv
`timescale 1ns/1ps
module sfa_array_ctrl_checker
    import sfa_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic spi_sel_n,
    input wire logic spi_miso_oe,
    input wire logic erase_valid,
    input wire logic erase_ready,
    input wire sfa_erase_t erase_kind,
    input wire logic [SFA_ADDR_W-1:0] erase_base,
    input wire logic [4:0] erase_size_log2,
    input wire logic prog_valid,
    input wire logic prog_ready,
    input wire logic [SFA_ADDR_W-1:0] prog_addr,
    input wire logic [7:0] prog_data,
    input wire logic [SFA_OTP_REGS-1:0] otp_lock
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence erase_wait;
        erase_valid && !erase_ready;
    endsequence
    sequence erase_take;
        erase_valid && erase_ready;
    endsequence
    hold_req_a: assert property (erase_wait |=> erase_valid && $stable(erase_base)
        && $stable(erase_kind) && $stable(erase_size_log2)) else $error("erase request changed");
    drop_req_a: assert property (erase_take |=> !erase_valid)
        else $error("erase request stayed");
    sector_size_a: assert property (erase_valid && erase_kind == SFA_ER_SECTOR |->
        erase_size_log2 == SFA_SZ_SECTOR && erase_base[15:0] == 16'h0000) else $error("bad sector erase");
    param_size_a: assert property (erase_valid && erase_kind == SFA_ER_PARAM |->
        erase_size_log2 == SFA_SZ_PARAM && erase_base[23:16] == 8'h00 && erase_base[12:0] == 13'h0000)
        else $error("bad block erase");
    bulk_size_a: assert property (erase_valid && erase_kind == SFA_ER_BULK |->
        erase_size_log2 == SFA_SZ_BULK && erase_base == 24'h000000) else $error("bad bulk erase");
    frame_end_a: assert property ($rose(erase_valid) |-> spi_sel_n && $past(spi_sel_n, 3))
        else $error("erase before frame end");
    miso_off_a: assert property (!spi_miso_oe)
        else $error("output driven");
    lock_keep_a: assert property (($past(otp_lock) & ~otp_lock) == '0)
        else $error("lock bit cleared");
    head_hold_a: assert property (prog_valid && !prog_ready |=> prog_valid
        && $stable(prog_addr) && $stable(prog_data)) else $error("program byte changed");
endmodule // sfa_array_ctrl_checker
bind sfa_array_ctrl sfa_array_ctrl_checker u_chk (
    .core_clk(core_clk),
    .nrst(nrst),
    .spi_sel_n(spi_sel_n),
    .spi_miso_oe(spi_miso_oe),
    .erase_valid(erase_valid),
    .erase_ready(erase_ready),
    .erase_kind(erase_kind),
    .erase_base(erase_base),
    .erase_size_log2(erase_size_log2),
    .prog_valid(prog_valid),
    .prog_ready(prog_ready),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .otp_lock(otp_lock)
);

// file: dv/sfa_array_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module sfa_array_ctrl_bench
    import sfa_pkg::*;
;
    int n_mismatch = 0;
    int compares = 0;
    logic core_clk;
    logic nrst;
    logic erase_ready;
    logic prog_ready;
    logic spi_clk, spi_sel_n, spi_mosi, spi_miso, spi_miso_oe, erase_valid, prog_valid, prog_overrun;
    sfa_erase_t erase_kind;
    logic [SFA_ADDR_W-1:0] erase_base, prog_addr;
    logic [4:0] erase_size_log2;
    logic [7:0] prog_data;
    logic [SFA_OTP_REGS-1:0] otp_lock;
    always #2.5 core_clk = ~core_clk;
    sfa_array_ctrl DUT (
        .core_clk(core_clk),
        .nrst(nrst),
        .spi_clk(spi_clk),
        .spi_sel_n(spi_sel_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .erase_valid(erase_valid),
        .erase_ready(erase_ready),
        .erase_kind(erase_kind),
        .erase_base(erase_base),
        .erase_size_log2(erase_size_log2),
        .prog_valid(prog_valid),
        .prog_ready(prog_ready),
        .prog_addr(prog_addr),
        .prog_data(prog_data),
        .prog_overrun(prog_overrun),
        .otp_lock(otp_lock)
    );
    sfa_spi_host host (
        .core_clk(core_clk),
        .spi_clk(spi_clk),
        .spi_sel_n(spi_sel_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe)
    );
    task automatic finish_test();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic do_cmd(input logic [7:0] op, input logic [23:0] a);
        host.start(op);
        host.put_addr(a);
        host.stop();
    endtask
    task automatic chk_erase(input sfa_erase_t k, input logic [23:0] b, input logic [4:0] s);
        for (int i = 0; i < 20 && erase_valid !== 1'b1; i++)
            @(negedge core_clk);
        `CHK("erase_valid", 1'b1, erase_valid)
        `CHK("erase_kind", k, erase_kind)
        `CHK("erase_base", b, erase_base)
        `CHK("erase_size", s, erase_size_log2)
        host.wait_n(3);
        erase_ready = 1'b1;
        host.wait_n(1);
        erase_ready = 1'b0;
        `CHK("erase_valid", 1'b0, erase_valid)
    endtask
    task automatic pop(input logic [23:0] a, input logic [7:0] d);
        for (int i = 0; i < 20 && prog_valid !== 1'b1; i++)
            @(negedge core_clk);
        `CHK("prog_valid", 1'b1, prog_valid)
        `CHK("prog_addr", a, prog_addr)
        `CHK("prog_data", d, prog_data)
        prog_ready = 1'b1;
        host.wait_n(1);
        prog_ready = 1'b0;
        host.wait_n(1);
    endtask
    task automatic t_erase();
        do_cmd(SFA_OP_SECTOR_ERASE, 24'h051234);
        chk_erase(SFA_ER_SECTOR, 24'h050000, SFA_SZ_SECTOR);
        do_cmd(SFA_OP_SECTOR_ERASE, 24'h00A000);
        chk_erase(SFA_ER_SECTOR, 24'h000000, SFA_SZ_SECTOR);
        do_cmd(SFA_OP_PARAM_ERASE, 24'h00A123);
        chk_erase(SFA_ER_PARAM, 24'h00A000, SFA_SZ_PARAM);
        do_cmd(SFA_OP_PARAM_ERASE, 24'h012000);
        host.wait_n(20);
        `CHK("erase_valid", 1'b0, erase_valid)
        host.start(SFA_OP_BULK_ERASE);
        host.stop();
        chk_erase(SFA_ER_BULK, 24'h000000, SFA_SZ_BULK);
        do_cmd(SFA_OP_SECTOR_ERASE, 24'h020000);
        do_cmd(SFA_OP_SECTOR_ERASE, 24'h030000);
        chk_erase(SFA_ER_SECTOR, 24'h020000, SFA_SZ_SECTOR);
        host.wait_n(20);
        `CHK("erase_valid", 1'b0, erase_valid)
    endtask
    task automatic t_prog();
        host.start(SFA_OP_PAGE_PROG);
        host.put_addr(24'h1234FE);
        for (int k = 0; k < 10; k++)
            host.put_byte(8'hA0 + 8'(k));
        host.stop();
        `CHK("prog_overrun", 1'b1, prog_overrun)
        for (int k = 0; k < 8; k++)
            pop({16'h1234, 8'hFE + 8'(k)}, 8'hA0 + 8'(k));
        pop(24'h123407, 8'hA9);
        `CHK("prog_valid", 1'b0, prog_valid)
        host.start(SFA_OP_PAGE_PROG);
        host.put_addr(24'h123400);
        host.put_byte(8'h55);
        host.stop();
        `CHK("prog_overrun", 1'b0, prog_overrun)
        pop(24'h123400, 8'h55);
    endtask
    task automatic t_lock();
        do_cmd(SFA_OP_OTP_LOCK, 24'h000020);
        host.wait_n(10);
        `CHK("otp_lock", 33'h100000000, otp_lock)
        do_cmd(SFA_OP_OTP_LOCK, 24'h000021);
        host.wait_n(10);
        `CHK("otp_lock", 33'h100000000, otp_lock)
    endtask
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        erase_ready = 1'b0;
        prog_ready = 1'b0;
        repeat (6) @(negedge core_clk);
        nrst = 1'b1;
        host.wait_n(4);
        t_erase();
        t_prog();
        t_lock();
        `CHK("miso_oe", 1'b0, spi_miso_oe)
        `CHK("miso", 1'b1, spi_miso)
        finish_test();
    end
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end
endmodule // sfa_array_ctrl_bench
